/* verilog/jah_ctrl.sv */
// control pins, interrupt and jitter attenuator configuration of the line interface unit
`timescale 1ns/1ns
`default_nettype none
module jah_ctrl (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rstn_in,
    input  wire logic                          reg_rst_n_in,
    input  wire logic                          host_mode_in,
    input  wire logic [jah_pkg::ADDR_W-1:0]    bus_addr_in,
    input  wire logic [jah_pkg::DATA_W-1:0]    bus_wdata_in,
    input  wire logic                          bus_wr_in,
    input  wire logic                          bus_rd_in,
    output logic      [jah_pkg::DATA_W-1:0]    bus_rdata_out,
    input  wire logic                          int_pin_in,
    output logic                               int_pin_out,
    output logic                               int_pin_oe_out,
    input  wire logic                          jit_sel_bit0_in,
    input  wire logic                          jit_sel_bit1_in,
    input  wire logic                          jit_path_select_in,
    input  wire logic                          signal_loss_in,
    input  wire logic                          rx_pos_raw_in,
    input  wire logic                          rx_neg_raw_in,
    output logic                               rx_pos_data_out,
    output logic                               rx_neg_data_out,
    output jah_pkg::jah_jit_cfg_t              jit_cfg_out
);

    jah_pkg::jah_state_t st_r;
    jah_pkg::jah_state_t st_nxt;

    function automatic jah_pkg::jah_jit_cfg_t jit_decode(input logic [1:0] sel, input logic path);
        jah_pkg::jah_jit_cfg_t c;
        c.tx_path = path;
        c.en      = 1'b1;
        case (jah_pkg::jah_jit_sel_t'(sel))
            jah_pkg::JIT_D16:  c.depth = jah_pkg::DEPTH_16;
            jah_pkg::JIT_D32:  c.depth = jah_pkg::DEPTH_32;
            jah_pkg::JIT_D128: c.depth = jah_pkg::DEPTH_128;
            default: begin
                c.depth = jah_pkg::DEPTH_0;
                c.en    = 1'b0;
            end
        endcase
        return c;
    endfunction

    logic [jah_pkg::EV_W-1:0] events;
    logic                     mute_en;
    logic                     hit_ctrl;
    logic                     hit_stat;
    logic                     hit_mask;
    logic                     hit_state;

    assign hit_ctrl  = bus_addr_in == jah_pkg::CTRL_OFS;
    assign hit_stat  = bus_addr_in == jah_pkg::STAT_OFS;
    assign hit_mask  = bus_addr_in == jah_pkg::MASK_OFS;
    assign hit_state = bus_addr_in == jah_pkg::STATE_OFS;

    always_comb begin
        st_nxt = st_r;
        st_nxt.host   = host_mode_in;
        st_nxt.loss_q = signal_loss_in;
        st_nxt.rdata  = '0;

        events = '0;
        events[jah_pkg::EV_LOSS_SET] = signal_loss_in & ~st_r.loss_q;
        events[jah_pkg::EV_LOSS_CLR] = ~signal_loss_in & st_r.loss_q;

        // command register writes
        if (bus_wr_in) begin
            if (hit_ctrl) begin
                st_nxt.ctrl = bus_wdata_in[jah_pkg::CTRL_W-1:0];
            end else if (hit_mask) begin
                st_nxt.mask = bus_wdata_in[jah_pkg::EV_W-1:0];
            end
        end

        // reads: unmapped offsets answer zero
        if (bus_rd_in) begin
            if (hit_ctrl) begin
                st_nxt.rdata[jah_pkg::CTRL_W-1:0] = st_r.ctrl;
            end else if (hit_stat) begin
                st_nxt.rdata[jah_pkg::EV_W-1:0] = st_r.status;
            end else if (hit_mask) begin
                st_nxt.rdata[jah_pkg::EV_W-1:0] = st_r.mask;
            end else if (hit_state) begin
                st_nxt.rdata[jah_pkg::ST_DEPTH_LO +: 8] = st_r.jit.depth;
                st_nxt.rdata[jah_pkg::ST_PATH_BIT]      = st_r.jit.tx_path;
                st_nxt.rdata[jah_pkg::ST_JEN_BIT]       = st_r.jit.en;
                st_nxt.rdata[jah_pkg::ST_LOSS_BIT]      = st_r.loss_q;
                st_nxt.rdata[jah_pkg::ST_HOST_BIT]      = st_r.host;
            end
        end

        // a read clears status, but an event in the same cycle survives it
        if (bus_rd_in && hit_stat) begin
            st_nxt.status = events;
        end else begin
            st_nxt.status = st_r.status | events;
        end

        // only an explicit low resets; the pad pull-up keeps an open pin inactive
        if (!reg_rst_n_in) begin
            st_nxt.ctrl   = jah_pkg::CTRL_RST;
            st_nxt.mask   = jah_pkg::MASK_RST;
            st_nxt.status = jah_pkg::STAT_RST;
        end

        // configuration: pins in hardware mode, control register in host mode
        if (host_mode_in) begin
            st_nxt.jit = jit_decode(st_nxt.ctrl[jah_pkg::CTRL_JSEL_HI:jah_pkg::CTRL_JSEL_LO],
                                    st_nxt.ctrl[jah_pkg::CTRL_JPATH_BIT]);
            mute_en = st_nxt.ctrl[jah_pkg::CTRL_MUTE_BIT];
        end else begin
            // open pins read low through the pull-downs: 16 bits, receive path
            st_nxt.jit = jit_decode({jit_sel_bit0_in, jit_sel_bit1_in},
                                    jit_path_select_in);
            mute_en = int_pin_in;
        end

        // muting both rails avoids a half-valid bipolar pair downstream
        st_nxt.rx_pos = rx_pos_raw_in & ~(mute_en & signal_loss_in);
        st_nxt.rx_neg = rx_neg_raw_in & ~(mute_en & signal_loss_in);

        st_nxt.int_act = host_mode_in
                       & st_nxt.ctrl[jah_pkg::CTRL_INTEN_BIT]
                       & (|(st_nxt.status & st_nxt.mask));
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            st_r <= jah_pkg::ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata_out   = st_r.rdata;
    assign int_pin_out     = ~st_r.int_act;
    assign int_pin_oe_out  = st_r.host;
    assign rx_pos_data_out = st_r.rx_pos;
    assign rx_neg_data_out = st_r.rx_neg;
    assign jit_cfg_out     = st_r.jit;

    // ---------------------------------------------------------------- checks
    sequence s_hw_pins(logic [1:0] sel);
        !host_mode_in && {jit_sel_bit0_in, jit_sel_bit1_in} == sel;
    endsequence

    // host mode must already hold a cycle earlier, or the first host cycle still shows the pin decode
    sequence s_quiet_host;
        host_mode_in ##1 host_mode_in && !bus_wr_in && reg_rst_n_in;
    endsequence

    sequence s_unmasked_event;
        host_mode_in && reg_rst_n_in && !bus_wr_in && st_r.ctrl[jah_pkg::CTRL_INTEN_BIT]
            && (|(events & st_r.mask));
    endsequence

    // read-clear checks assume no loss edge in the read cycle; the rising-edge race has its own check
    sequence s_status_read_quiet;
        bus_rd_in && hit_stat && events == '0;
    endsequence

    AST_REGRST_DEFAULTS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !reg_rst_n_in |=> st_r.ctrl == jah_pkg::CTRL_RST && st_r.mask == jah_pkg::MASK_RST
            && st_r.status == jah_pkg::STAT_RST && !st_r.int_act)
        else $error("register reset did not restore defaults");

    AST_REGRST_IDLE_KEEPS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        reg_rst_n_in && !bus_wr_in |=> $stable(st_r.ctrl) && $stable(st_r.mask))
        else $error("command registers changed without write or reset");

    AST_INT_DRIVEN_LOW: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_unmasked_event |=> !int_pin_out && int_pin_oe_out)
        else $error("unmasked event did not pull interrupt pin low");

    AST_INT_SUPPRESSED: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !st_r.ctrl[jah_pkg::CTRL_INTEN_BIT] |-> int_pin_out)
        else $error("interrupt signalled while disabled");

    AST_HW_PIN_INPUT: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !host_mode_in |=> !int_pin_oe_out && int_pin_out)
        else $error("shared pin driven in hardware mode");

    AST_MUTE_ON_LOSS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !host_mode_in && int_pin_in && signal_loss_in |=> !rx_pos_data_out && !rx_neg_data_out)
        else $error("receive data not muted on signal loss");

    AST_RX_PASS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !signal_loss_in |=> rx_pos_data_out == $past(rx_pos_raw_in) && rx_neg_data_out == $past(rx_neg_raw_in))
        else $error("receive data altered without signal loss");

    AST_JIT_DEPTH32: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_hw_pins(2'b01) |=> jit_cfg_out.en && jit_cfg_out.depth == jah_pkg::DEPTH_32)
        else $error("select 01 did not give 32 bit fifo");

    AST_JIT_DEPTH128: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_hw_pins(2'b10) |=> jit_cfg_out.en && jit_cfg_out.depth == jah_pkg::DEPTH_128)
        else $error("select 10 did not give 128 bit fifo");

    AST_JIT_DISABLED: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_hw_pins(2'b11) |=> !jit_cfg_out.en)
        else $error("select 11 did not disable attenuator");

    AST_JIT_HOST_IGNORES_PINS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_quiet_host |=> $stable(jit_cfg_out))
        else $error("select pins changed configuration in host mode");

    AST_JIT_OPEN_DEFAULT: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_hw_pins(2'b00) && !jit_path_select_in
            |=> jit_cfg_out.en && jit_cfg_out.depth == jah_pkg::DEPTH_16 && !jit_cfg_out.tx_path)
        else $error("open select pins did not give 16 bit receive path");

    AST_JIT_PATH: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !host_mode_in |=> jit_cfg_out.tx_path == $past(jit_path_select_in))
        else $error("path select not followed");

    AST_STAT_SET_WINS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        reg_rst_n_in && bus_rd_in && hit_stat && events[jah_pkg::EV_LOSS_SET]
            |=> st_r.status[jah_pkg::EV_LOSS_SET])
        else $error("event lost against status read");

    AST_STAT_READ_DATA: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        bus_rd_in && hit_stat
            |=> bus_rdata_out[jah_pkg::EV_W-1:0] == $past(st_r.status)
            && bus_rdata_out[jah_pkg::DATA_W-1:jah_pkg::EV_W] == '0)
        else $error("status read returned wrong word");

    AST_STAT_READ_CLEARS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_status_read_quiet |=> st_r.status == jah_pkg::STAT_RST)
        else $error("status not cleared by read");

    AST_INT_CLEAR_ON_READ: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        s_status_read_quiet |=> int_pin_out)
        else $error("interrupt still low after status read");

    AST_RDATA_IDLE_ZERO: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !bus_rd_in |=> bus_rdata_out == '0)
        else $error("read data stood without a read strobe");

    AST_MASK_READ_UPPER_ZERO: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        bus_rd_in && hit_mask |=> bus_rdata_out[jah_pkg::DATA_W-1:jah_pkg::EV_W] == '0)
        else $error("mask read upper bits not zero");

    AST_STATE_HOST_BIT: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        bus_rd_in && hit_state |=> bus_rdata_out[jah_pkg::ST_HOST_BIT] == $past(int_pin_oe_out))
        else $error("state word host bit wrong");

    AST_REGRST_HOST_CFG: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !reg_rst_n_in && host_mode_in
            |=> jit_cfg_out.en && jit_cfg_out.depth == jah_pkg::DEPTH_16 && !jit_cfg_out.tx_path)
        else $error("register reset did not restore default configuration");

    AST_INT_OE_HOST: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        host_mode_in |=> int_pin_oe_out)
        else $error("shared pin not driven in host mode");

    AST_HW_MUTE_OFF: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !host_mode_in && !int_pin_in
            |=> rx_pos_data_out == $past(rx_pos_raw_in) && rx_neg_data_out == $past(rx_neg_raw_in))
        else $error("receive data muted with mute input low");

    AST_STAT_FALL_SET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        reg_rst_n_in && events[jah_pkg::EV_LOSS_CLR] |=> st_r.status[jah_pkg::EV_LOSS_CLR])
        else $error("loss clear event not recorded");

    AST_JIT_OFF_ZERO_DEPTH: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !jit_cfg_out.en |-> jit_cfg_out.depth == jah_pkg::DEPTH_0)
        else $error("disabled attenuator reports a depth");

endmodule
`default_nettype wire

/* verilog/jah_pkg.sv */
// shared constants and types of the jitter attenuator configuration and host control block
`default_nettype none
package jah_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets, one aligned word each
    localparam logic [ADDR_W-1:0] CTRL_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] MASK_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] STATE_OFS = 8'h0C;

    // control register fields
    localparam int CTRL_W         = 5;
    localparam int CTRL_INTEN_BIT = 0;
    localparam int CTRL_JSEL_LO   = 1;
    localparam int CTRL_JSEL_HI   = 2;
    localparam int CTRL_JPATH_BIT = 3;
    localparam int CTRL_MUTE_BIT  = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // event bits, shared by status and mask
    localparam int EV_W        = 2;
    localparam int EV_LOSS_SET = 0;
    localparam int EV_LOSS_CLR = 1;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;
    localparam logic [EV_W-1:0] STAT_RST = 2'h0;

    // state word fields
    localparam int ST_DEPTH_LO = 0;
    localparam int ST_PATH_BIT = 8;
    localparam int ST_JEN_BIT  = 9;
    localparam int ST_LOSS_BIT = 10;
    localparam int ST_HOST_BIT = 11;

    // selection code is {bit0, bit1}
    typedef enum logic [1:0] {
        JIT_D16  = 2'b00,
        JIT_D32  = 2'b01,
        JIT_D128 = 2'b10,
        JIT_OFF  = 2'b11
    } jah_jit_sel_t;

    localparam logic [7:0] DEPTH_16  = 8'h10;
    localparam logic [7:0] DEPTH_32  = 8'h20;
    localparam logic [7:0] DEPTH_128 = 8'h80;
    localparam logic [7:0] DEPTH_0   = 8'h00;

    typedef struct packed {
        logic       en;
        logic       tx_path;
        logic [7:0] depth;
    } jah_jit_cfg_t;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [EV_W-1:0]   mask;
        logic [EV_W-1:0]   status;
        logic [DATA_W-1:0] rdata;
        logic              loss_q;
        logic              host;
        logic              rx_pos;
        logic              rx_neg;
        jah_jit_cfg_t      jit;
        logic              int_act;
    } jah_state_t;

    localparam jah_state_t ST_RST = '0;

endpackage
`default_nettype wire

/* verification/jah_host_model.sv */
// host processor model that drives the register port of the control block
`timescale 1ns/1ns
`default_nettype none
module jah_host_model (
    input  wire logic                       clk_sys_in,
    input  wire logic [jah_pkg::DATA_W-1:0] rdata_in,
    output logic      [jah_pkg::ADDR_W-1:0] addr_out,
    output logic      [jah_pkg::DATA_W-1:0] wdata_out,
    output logic                            wr_out,
    output logic                            rd_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 32'h0000_0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // released address and data lines show the inverse so stale values never pass
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_out    <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge clk_sys_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        rd_out   <= 1'b1;
        addr_out <= a;
        @(posedge clk_sys_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the control pin and interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic                  clk, rstn, reg_rst_n, host, sel0, sel1, path, loss, rawp, rawn, mute_drv;
    logic [7:0]            addr;
    logic [31:0]           wdata, rdata, v;
    logic                  wr, rd, int_out, int_oe, rxp, rxn;
    wire logic             int_pin;
    jah_pkg::jah_jit_cfg_t cfg;
    int                    fails, checks;
    localparam logic [7:0] DEP[4] = '{8'h10, 8'h20, 8'h80, 8'h00};

    // shared pin: device drives it in host mode, otherwise the board level
    assign int_pin = int_oe ? int_out : mute_drv;

    jah_host_model jah_host_model_i (.clk_sys_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

    jah_ctrl jah_ctrl_i (.clk_sys_in(clk), .rstn_in(rstn), .reg_rst_n_in(reg_rst_n), .host_mode_in(host),
        .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
        .int_pin_in(int_pin), .int_pin_out(int_out), .int_pin_oe_out(int_oe), .jit_sel_bit0_in(sel0),
        .jit_sel_bit1_in(sel1), .jit_path_select_in(path), .signal_loss_in(loss), .rx_pos_raw_in(rawp),
        .rx_neg_raw_in(rawn), .rx_pos_data_out(rxp), .rx_neg_data_out(rxn), .jit_cfg_out(cfg));

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #20000;
        fails++;
        end_of_test();
    end

    initial begin
        {rstn, host, sel0, sel1, path, loss, mute_drv} = 7'h00;
        {reg_rst_n, rawp, rawn} = 3'b111;
        fails  = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wait_cyc(3);
        chk("oe_hw", 32'(int_oe), 32'h0000_0000);
        chk("cfg_open", 32'(cfg), 32'h0000_0210);
        // every select code with both path levels
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {sel0, sel1, path} <= i[2:0];
            wait_cyc(2);
            chk("depth", 32'(cfg.depth), 32'(DEP[i[2:1]]));
            chk("enable", 32'(cfg.en), 32'(i[2:1] != 2'b11));
            if (i[2:1] != 2'b11) chk("path", 32'(cfg.tx_path), 32'(i[0]));
        end
        @(posedge clk);
        mute_drv <= 1'b1;
        loss     <= 1'b1;
        wait_cyc(2);
        chk("muted", {30'h0, rxp, rxn}, 32'h0000_0000);
        @(posedge clk);
        mute_drv <= 1'b0;
        rawn     <= 1'b0;
        wait_cyc(2);
        chk("unmuted", {30'h0, rxp, rxn}, 32'h0000_0002);
        @(posedge clk);
        loss <= 1'b0;
        host <= 1'b1;
        wait_cyc(3);
        chk("oe_host", 32'(int_oe), 32'h0000_0001);
        chk("cfg_host", 32'(cfg), 32'h0000_0210);
        // drop events recorded in hardware mode before arming the interrupt
        jah_host_model_i.bus_rd(jah_pkg::STAT_OFS, v);
        jah_host_model_i.bus_wr(jah_pkg::MASK_OFS, 32'h0000_0003);
        jah_host_model_i.bus_wr(jah_pkg::CTRL_OFS, 32'h0000_0001);
        wait_cyc(2);
        chk("int_idle", 32'(int_out), 32'h0000_0001);
        @(posedge clk);
        loss <= 1'b1;
        wait_cyc(3);
        chk("int_low", 32'(int_out), 32'h0000_0000);
        jah_host_model_i.bus_rd(jah_pkg::STAT_OFS, v);
        chk("status_rise", v, 32'h0000_0001);
        chk("int_cleared", 32'(int_out), 32'h0000_0001);
        jah_host_model_i.bus_wr(jah_pkg::CTRL_OFS, 32'h0000_0000);
        @(posedge clk);
        loss <= 1'b0;
        wait_cyc(3);
        chk("int_disabled", 32'(int_out), 32'h0000_0001);
        jah_host_model_i.bus_rd(jah_pkg::STAT_OFS, v);
        chk("status_fall", v, 32'h0000_0002);
        // a rise in the very cycle of a status read must survive the clear
        fork
            jah_host_model_i.bus_rd(jah_pkg::STAT_OFS, v);
            begin
                @(posedge clk);
                loss <= 1'b1;
            end
        join
        chk("status_race_old", v, 32'h0000_0000);
        jah_host_model_i.bus_rd(jah_pkg::STAT_OFS, v);
        chk("status_set_wins", v, 32'h0000_0001);
        jah_host_model_i.bus_rd(8'h40, v);
        chk("unmapped", v, 32'h0000_0000);
        jah_host_model_i.bus_wr(jah_pkg::CTRL_OFS, 32'h0000_001F);
        jah_host_model_i.bus_rd(jah_pkg::CTRL_OFS, v);
        chk("ctrl_kept", v, 32'h0000_001F);
        @(posedge clk);
        reg_rst_n <= 1'b0;
        @(posedge clk);
        reg_rst_n <= 1'b1;
        jah_host_model_i.bus_rd(jah_pkg::CTRL_OFS, v);
        chk("ctrl_reset", v, 32'h0000_0000);
        jah_host_model_i.bus_rd(jah_pkg::MASK_OFS, v);
        chk("mask_reset", v, 32'h0000_0000);
        wait_cyc(2);
        chk("cfg_reset", 32'(cfg), 32'h0000_0210);
        jah_host_model_i.bus_rd(jah_pkg::STATE_OFS, v);
        chk("state_word", v, 32'h0000_0E10);
        end_of_test();
    end
endmodule
`default_nettype wire
